// ---- core/ctimer_pkg.sv ----
// Constants shared by the compact timer design files
package ctimer_pkg;
	localparam logic [2:0] ADDR_CONTROL_ZERO = 3'h0;
	localparam logic [2:0] ADDR_CONTROL_ONE = 3'h1;
	localparam logic [2:0] ADDR_COUNT_LOW = 3'h2;
	localparam logic [2:0] ADDR_COUNT_HIGH = 3'h3;
	localparam logic [2:0] ADDR_CMPA_LOW = 3'h4;
	localparam logic [2:0] ADDR_CMPA_HIGH = 3'h5;
	localparam logic [2:0] ADDR_PERIOD = 3'h6;
	localparam int CZ_PAUSE_BIT = 7;
	localparam int CZ_CLKSEL_LSB = 4;
	localparam int CZ_ENABLE_BIT = 3;
	localparam int CO_MODE_LSB = 6;
	localparam int CO_FUNC_LSB = 4;
	localparam int CO_INIT_BIT = 3;
	localparam int CO_INVERT_BIT = 2;
	localparam int CO_SWAP_BIT = 1;
	localparam int CO_CLRSEL_BIT = 0;
	localparam logic [7:0] CONTROL_ZERO_MASK = 8'hF8;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [1:0] MODE_COMPARE = 2'h0;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TIMER = 2'h3;
	localparam logic [1:0] FUNC_NONE = 2'h0;
	localparam logic [1:0] FUNC_LOW = 2'h1;
	localparam logic [1:0] FUNC_HIGH = 2'h2;
	localparam logic [1:0] FUNC_TOGGLE = 2'h3;
	localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
	localparam logic [2:0] CLK_SYS = 3'h1;
	localparam logic [2:0] CLK_H_DIV16 = 3'h2;
	localparam logic [2:0] CLK_H_DIV64 = 3'h3;
	localparam logic [2:0] CLK_SUB_A = 3'h4;
	localparam logic [2:0] CLK_SUB_B = 3'h5;
	localparam logic [2:0] CLK_PIN_RISE = 3'h6;
	localparam logic [2:0] CLK_PIN_FALL = 3'h7;
	localparam logic [5:0] SUB_DIV_COUNT = 6'h3F;
	localparam int PRESCALE_WIDTH = 6;
	typedef enum logic [1:0] {
		RUN_IDLE = 2'b00,
		RUN_COUNT = 2'b01,
		RUN_PAUSED = 2'b11
	} run_state_t;
endpackage : ctimer_pkg

// ---- core/ctimer_prescale.sv ----
// Count clock selection: internal divided rates and the external pin
`timescale 1ns/1ps
module ctimer_prescale
	import ctimer_pkg::*;
(
	input wire logic clk_in, // System clock
	input wire logic rstn_in, // Synchronous reset, active low
	input wire logic [2:0] select_in, // Count clock source code
	input wire logic pin_in, // External count pin, asynchronous
	output logic tick_out // One-cycle count enable
);
	typedef struct packed {
		logic [PRESCALE_WIDTH-1:0] div;
		logic [PRESCALE_WIDTH-1:0] sub;
		logic pin_meta;
		logic pin_sync;
		logic pin_last;
		logic tick;
	} pre_state_t;
	pre_state_t st, next_st;
	logic sub_wrap;

	always_comb begin
		next_st = st;
		next_st.div = st.div + 6'h01;
		sub_wrap = (st.sub == SUB_DIV_COUNT);
		next_st.sub = sub_wrap ? 6'h00 : st.sub + 6'h01;
		next_st.pin_meta = pin_in;
		next_st.pin_sync = st.pin_meta;
		next_st.pin_last = st.pin_sync;
		// Dividers stand in for the other internal oscillators
		case (select_in)
			CLK_SYS_DIV4: next_st.tick = (st.div[1:0] == 2'h3);
			CLK_SYS: next_st.tick = 1'b1;
			CLK_H_DIV16: next_st.tick = (st.div[3:0] == 4'hF);
			CLK_H_DIV64: next_st.tick = (st.div == 6'h3F);
			CLK_SUB_A, CLK_SUB_B: next_st.tick = sub_wrap;
			CLK_PIN_RISE: next_st.tick = st.pin_sync & ~st.pin_last;
			CLK_PIN_FALL: next_st.tick = ~st.pin_sync & st.pin_last;
			default: next_st.tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_out = st.tick;
endmodule : ctimer_prescale

// ---- core/ctimer_regs.sv ----
// Byte register file of the compact timer
`timescale 1ns/1ps
module ctimer_regs
	import ctimer_pkg::*;
(
	input wire logic clk_in, // System clock
	input wire logic rstn_in, // Synchronous reset, active low
	input wire logic [2:0] addr_in, // Register address
	input wire logic [7:0] wdata_in, // Write data
	input wire logic wr_in, // Write strobe
	input wire logic rd_in, // Read strobe
	input wire logic [15:0] count_in, // Live counter value
	output logic [7:0] rdata_out, // Read data, one cycle later
	output logic [7:0] control_zero_out, // Enable, pause, clock select
	output logic [7:0] control_one_out, // Mode and output control
	output logic [15:0] compare_a_out, // Comparator A value
	output logic [7:0] period_out // Comparator P value
);
	typedef struct packed {
		logic [7:0] control_zero;
		logic [7:0] control_one;
		logic [15:0] compare_a;
		logic [7:0] period;
		logic [7:0] rdata;
	} reg_state_t;
	reg_state_t st, next_st;

	always_comb begin
		next_st = st;
		next_st.rdata = BYTE_RESET;
		if (wr_in) begin
			case (addr_in)
				ADDR_CONTROL_ZERO:
					next_st.control_zero = wdata_in & CONTROL_ZERO_MASK;
				ADDR_CONTROL_ONE: next_st.control_one = wdata_in;
				ADDR_CMPA_LOW: next_st.compare_a[7:0] = wdata_in;
				ADDR_CMPA_HIGH: next_st.compare_a[15:8] = wdata_in;
				ADDR_PERIOD: next_st.period = wdata_in;
				default: next_st.period = st.period;
			endcase
		end
		if (rd_in) begin
			case (addr_in)
				ADDR_CONTROL_ZERO: next_st.rdata = st.control_zero;
				ADDR_CONTROL_ONE: next_st.rdata = st.control_one;
				ADDR_COUNT_LOW: next_st.rdata = count_in[7:0];
				ADDR_COUNT_HIGH: next_st.rdata = count_in[15:8];
				ADDR_CMPA_LOW: next_st.rdata = st.compare_a[7:0];
				ADDR_CMPA_HIGH: next_st.rdata = st.compare_a[15:8];
				ADDR_PERIOD: next_st.rdata = st.period;
				default: next_st.rdata = BYTE_RESET;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rdata_out = st.rdata;
	assign control_zero_out = st.control_zero;
	assign control_one_out = st.control_one;
	assign compare_a_out = st.compare_a;
	assign period_out = st.period;
endmodule : ctimer_regs

// ---- core/compact_timer.sv ----
// Top of the 16-bit compact timer with compare and PWM output
// Overview of operation
// - Counter readable as two zero-reset bytes
// - Compare A value: two RW bytes, reset zero
// - Period byte compared with counter high byte
// - Period N gives 256N clocks, zero 65536
// - Mode 00: compare output, three clear sources
// - Clear-select low: P match clears, flags both
// - Clear-select high: A match clears, A flag only
// - Compare A zero: overflow, no A flag
// - Compare mode pin changes on A only
// - Function field: high, low, toggle, none
// - Enable rise sets compare pin to initial level, PWM pin to its inverse
// - Mode 11 like compare mode, pin idle
// - Mode 10 PWM ignores clear-select
// - Swap zero: period from P, duty A
// - Duty at or above period gives 100%
// - Swap one: period from A, duty P
// - PWM raises a flag per comparator
// - PWM level, function and polarity controls
// - PWM counting continues while pin forced
// - Compare codes 01 low, 10 high, 11 toggle
// - Enable rise zeroes counter; fall keeps it
// - Pause holds counter, release resumes
// - Clock select: internal rates or pin edges
`timescale 1ns/1ps
module compact_timer
	import ctimer_pkg::*;
(
	input wire logic clk_in, // 125 MHz system clock
	input wire logic rstn_in, // Synchronous reset, active low
	input wire logic [2:0] addr_in, // Register address
	input wire logic [7:0] wdata_in, // Register write data
	input wire logic wr_in, // Write strobe
	input wire logic rd_in, // Read strobe
	input wire logic external_count_pin_in, // External count clock pin
	output logic [7:0] rdata_out, // Read data
	output logic timer_output_pin_out, // Timer output level
	output logic timer_output_active_out, // High while pin is used
	output logic match_a_flag_out, // One-cycle comparator A event
	output logic match_p_flag_out // One-cycle comparator P event
);
	typedef struct packed {
		run_state_t run;
		logic [15:0] count;
		logic enable_last;
		logic cmp_level;
		logic pwm_level;
		logic pin;
		logic pin_active;
		logic flag_a;
		logic flag_p;
	} top_state_t;
	top_state_t st, next_st;

	logic [7:0] control_zero;
	logic [7:0] control_one;
	logic [15:0] compare_a;
	logic [7:0] period;
	logic tick;
	logic enable;
	logic pause;
	logic [1:0] mode;
	logic [1:0] func;
	logic init_level;
	logic invert;
	logic swap;
	logic clear_sel;
	logic [15:0] next_count;
	logic a_hit;
	logic p_hit;
	logic wrap;
	logic clear_now;
	logic raise_a;
	logic raise_p;
	logic [16:0] duty_end;
	logic [16:0] period_len;
	logic duty_on;
	logic pwm_raw;

	ctimer_regs u_regs (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.count_in(st.count),
		.rdata_out(rdata_out),
		.control_zero_out(control_zero),
		.control_one_out(control_one),
		.compare_a_out(compare_a),
		.period_out(period)
	);

	ctimer_prescale u_prescale (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.select_in(control_zero[CZ_CLKSEL_LSB +: 3]),
		.pin_in(external_count_pin_in),
		.tick_out(tick)
	);

	// Length of a period-register interval; zero means the full range
	function automatic logic [16:0] period_span(input logic [7:0] value);
		period_span = (value == 8'h00) ? 17'h10000 : {1'b0, value, 8'h00};
	endfunction : period_span

	always_comb begin
		enable = control_zero[CZ_ENABLE_BIT];
		pause = control_zero[CZ_PAUSE_BIT];
		mode = control_one[CO_MODE_LSB +: 2];
		func = control_one[CO_FUNC_LSB +: 2];
		init_level = control_one[CO_INIT_BIT];
		invert = control_one[CO_INVERT_BIT];
		swap = control_one[CO_SWAP_BIT];
		clear_sel = control_one[CO_CLRSEL_BIT];
		next_count = st.count + 16'h0001;
		wrap = (st.count == COUNT_MAX);
		// Compare on the value the counter is about to take
		a_hit = (compare_a != COUNT_RESET) && (next_count == compare_a);
		p_hit = (period != BYTE_RESET) && (next_count[7:0] == 8'h00)
			&& (next_count[15:8] == period);
		raise_a = 1'b0;
		raise_p = 1'b0;
		clear_now = 1'b0;
		if (mode == MODE_PWM) begin
			// Clear-select is ignored here; swap picks the clearing side
			raise_a = a_hit;
			raise_p = p_hit || (period == BYTE_RESET && wrap);
			clear_now = swap ? a_hit : raise_p;
		end else if (clear_sel) begin
			raise_a = a_hit;
			clear_now = a_hit;
		end else begin
			raise_a = a_hit;
			raise_p = p_hit || (period == BYTE_RESET && wrap);
			clear_now = raise_p;
		end
		// PWM duty: active while the counter is below the duty end
		duty_end = swap ? period_span(period) : {1'b0, compare_a};
		period_len = swap ? {1'b0, compare_a} : period_span(period);
		duty_on = ({1'b0, st.count} < duty_end)
			|| (duty_end >= period_len);
		pwm_raw = duty_on ? init_level : ~init_level;

		next_st = st;
		next_st.enable_last = enable;
		next_st.flag_a = 1'b0;
		next_st.flag_p = 1'b0;
		case (st.run)
			RUN_IDLE: begin
				if (enable) begin
					next_st.run = pause ? RUN_PAUSED : RUN_COUNT;
				end
			end
			RUN_COUNT: begin
				if (!enable) begin
					next_st.run = RUN_IDLE;
				end else if (pause) begin
					next_st.run = RUN_PAUSED;
				end else if (tick) begin
					next_st.count = clear_now ? COUNT_RESET : next_count;
					next_st.flag_a = raise_a;
					next_st.flag_p = raise_p;
					if (raise_a && mode == MODE_COMPARE) begin
						case (func)
							FUNC_LOW: next_st.cmp_level = 1'b0;
							FUNC_HIGH: next_st.cmp_level = 1'b1;
							FUNC_TOGGLE: next_st.cmp_level = ~st.cmp_level;
							default: next_st.cmp_level = st.cmp_level;
						endcase
					end
				end
			end
			RUN_PAUSED: begin
				if (!enable) begin
					next_st.run = RUN_IDLE;
				end else if (!pause) begin
					next_st.run = RUN_COUNT;
				end
			end
			default: next_st.run = RUN_IDLE;
		endcase
		if (enable && !st.enable_last) begin
			next_st.count = COUNT_RESET;
			next_st.cmp_level = init_level;
			next_st.flag_a = 1'b0;
			next_st.flag_p = 1'b0;
		end
		// PWM waveform tracks the counter only for function 10; other codes force a level
		case (func)
			FUNC_NONE: next_st.pwm_level = ~init_level;
			FUNC_LOW: next_st.pwm_level = init_level;
			FUNC_HIGH: next_st.pwm_level = pwm_raw;
			default: next_st.pwm_level = ~init_level;
		endcase
		if (enable && !st.enable_last) begin
			next_st.pwm_level = ~init_level;
		end
		case (mode)
			MODE_COMPARE: begin
				next_st.pin = next_st.cmp_level ^ invert;
				next_st.pin_active = 1'b1;
			end
			MODE_PWM: begin
				next_st.pin = next_st.pwm_level ^ invert;
				next_st.pin_active = 1'b1;
			end
			default: begin
				next_st.pin = 1'b0;
				next_st.pin_active = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign timer_output_pin_out = st.pin;
	assign timer_output_active_out = st.pin_active;
	assign match_a_flag_out = st.flag_a;
	assign match_p_flag_out = st.flag_p;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	no_p_clrsel_a: assert property ((mode == MODE_COMPARE && clear_sel
		&& $stable(control_one)) |=> !match_p_flag_out)
		else $error("P flag raised with A clear");
	zero_a_flag_a: assert property ((compare_a == COUNT_RESET
		&& $stable(compare_a)) |=> !match_a_flag_out)
		else $error("A flag raised with zero compare");
	enable_rise_a: assert property ((enable && !st.enable_last)
		|=> st.count == COUNT_RESET)
		else $error("Counter not zeroed on enable");
	pause_hold_a: assert property ((st.run == RUN_PAUSED && pause
		&& enable) |=> $stable(st.count))
		else $error("Counter moved while paused");
	step_one_a: assert property ((st.run == RUN_COUNT && enable && !pause
		&& tick && !clear_now && st.enable_last)
		|=> st.count == $past(st.count) + 16'h0001)
		else $error("Counter did not step");
	timer_pin_a: assert property ((mode == MODE_TIMER)
		|=> !timer_output_active_out)
		else $error("Pin driven in timer mode");
	init_level_a: assert property ((enable && !st.enable_last
		&& mode == MODE_COMPARE && $stable(control_one))
		|=> timer_output_pin_out == (init_level ^ invert))
		else $error("Pin not at initial level");
	p_no_pin_a: assert property ((mode == MODE_COMPARE && !raise_a
		&& !(enable && !st.enable_last) && $stable(control_one))
		|=> $stable(timer_output_pin_out))
		else $error("Pin moved without A match");
	p_clear_a: assert property ((mode == MODE_COMPARE && !clear_sel
		&& st.run == RUN_COUNT && enable && !pause && tick && p_hit
		&& st.enable_last) |=> st.count == COUNT_RESET ##0
		match_p_flag_out)
		else $error("P match did not clear");


	// Register port: read data live for one cycle only, then zero
	rdata_idle_a: assert property (
		!rd_in
		|=> rdata_out == BYTE_RESET)
		else $error("Read data not zero when idle");
	count_low_a: assert property (
		(rd_in && addr_in == ADDR_COUNT_LOW)
		|=> rdata_out == $past(st.count[7:0]))
		else $error("Counter low byte read wrong");
	count_high_a: assert property (
		(rd_in && addr_in == ADDR_COUNT_HIGH)
		|=> rdata_out == $past(st.count[15:8]))
		else $error("Counter high byte read wrong");
	cmpa_write_a: assert property (
		(wr_in && addr_in == ADDR_CMPA_LOW)
		|=> compare_a[7:0] == $past(wdata_in))
		else $error("Compare A low byte not stored");
	period_write_a: assert property (
		(wr_in && addr_in == ADDR_PERIOD)
		|=> period == $past(wdata_in))
		else $error("Period byte not stored");

	// Counter movement: only on a tick or an enable rise
	idle_hold_a: assert property (
		(st.run == RUN_IDLE && !enable)
		|=> $stable(st.count))
		else $error("Counter moved while disabled");
	no_tick_hold_a: assert property (
		(st.run == RUN_COUNT && enable && st.enable_last
		&& !tick)
		|=> $stable(st.count))
		else $error("Counter moved without a tick");
	a_clear_a: assert property (
		(mode != MODE_PWM && clear_sel && st.run == RUN_COUNT
		&& enable && !pause && tick && a_hit && st.enable_last)
		|=> st.count == COUNT_RESET ##0 match_a_flag_out)
		else $error("A match did not clear");

	// PWM: both comparators flag, swap moves the clear to A
	pwm_a_flag_a: assert property (
		(mode == MODE_PWM && st.run == RUN_COUNT && enable
		&& !pause && tick && a_hit && st.enable_last)
		|=> match_a_flag_out)
		else $error("PWM A match without flag");
	pwm_p_flag_a: assert property (
		(mode == MODE_PWM && st.run == RUN_COUNT && enable
		&& !pause && tick && p_hit && st.enable_last)
		|=> match_p_flag_out)
		else $error("PWM P match without flag");
	swap_clear_a: assert property (
		(mode == MODE_PWM && swap && st.run == RUN_COUNT
		&& enable && !pause && tick && a_hit && st.enable_last)
		|=> st.count == COUNT_RESET)
		else $error("Swapped PWM did not clear on A");
	pwm_forced_a: assert property (
		(mode == MODE_PWM && func == FUNC_NONE)
		|=> timer_output_pin_out
		== ($past(init_level) ^ $past(invert) ^ 1'b1))
		else $error("Forced PWM pin not inactive");

	cover_swap_c: cover property (mode == MODE_PWM && swap
		&& match_a_flag_out);
	cover_a_match_c: cover property (match_a_flag_out);
	cover_p_match_c: cover property (match_p_flag_out);
	cover_pwm_c: cover property (mode == MODE_PWM && timer_output_pin_out);
	cover_pause_c: cover property (st.run == RUN_PAUSED);
endmodule : compact_timer

// ---- tb/compact_timer_test.sv ----
// Self-checking bench for the compact timer
`timescale 1ns/1ps
module compact_timer_test;
	import ctimer_pkg::*;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [2:0] addr_in = 3'h0;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic ext_pin = 1'b0;
	logic [7:0] rdata_out;
	logic pin_out;
	logic active_out;
	logic flag_a;
	logic flag_p;
	int mismatches = 0;
	int total_checks = 0;
	// Bit 8 marks a read whose value is only kept, not compared
	logic [8:0] exp_q[$];
	logic [8:0] e_now;
	logic rd_seen = 1'b0;
	logic [7:0] last_rd;
	logic [7:0] v;
	logic last_pin;
	logic [7:0] pw_c1[6];
	logic [15:0] pw_d[6];
	int pw_h[6];
	int divs[3];
	int per, high, other, edges, np, i;

	always #4 clk_in = ~clk_in;

	compact_timer i_dut (
		.clk_in(clk_in), // Clock
		.rstn_in(rstn_in), // Reset
		.addr_in(addr_in), // Address
		.wdata_in(wdata_in), // Write data
		.wr_in(wr_in), // Write strobe
		.rd_in(rd_in), // Read strobe
		.external_count_pin_in(ext_pin), // Count pin
		.rdata_out(rdata_out), // Read data
		.timer_output_pin_out(pin_out), // Pin level
		.timer_output_active_out(active_out), // Pin in use
		.match_a_flag_out(flag_a), // A event
		.match_p_flag_out(flag_p) // P event
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%0h expected=%0h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [8:0] e);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		exp_q.push_back(e);
		@(posedge clk_in);
		rd_in <= 1'b0;
	endtask : rd

	// Read data stand only in the cycle after the strobe
	always @(posedge clk_in) rd_seen <= rd_in;
	always @(negedge clk_in) begin
		if (rd_seen === 1'b1) begin
			e_now = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h0FF;
			if (e_now[8]) begin
				last_rd = rdata_out;
			end else begin
				check(rdata_out, e_now[7:0]);
			end
		end
	end

	// Counter stopped while the new setup is written, then a fresh start
	task automatic setup(input logic [7:0] c1, input logic [15:0] a,
		input logic [7:0] p, input logic [2:0] cs);
		wr(ADDR_CONTROL_ZERO, 8'h00);
		wr(ADDR_CONTROL_ONE, c1);
		wr(ADDR_CMPA_LOW, a[7:0]);
		wr(ADDR_CMPA_HIGH, a[15:8]);
		wr(ADDR_PERIOD, p);
		wr(ADDR_CONTROL_ZERO, {1'b0, cs, 1'b1, 3'h0});
	endtask : setup

	// One full span between two events of the chosen comparator
	task automatic measure(input bit on_p);
		int n;
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while ((on_p ? flag_p : flag_a) !== 1'b1 && n < 70000);
		per = 0;
		high = 0;
		other = 0;
		edges = 0;
		last_pin = pin_out;
		do begin
			@(negedge clk_in);
			per++;
			high += (pin_out === 1'b1);
			other += ((on_p ? flag_a : flag_p) === 1'b1);
			edges += (pin_out !== last_pin);
			last_pin = pin_out;
		end while ((on_p ? flag_p : flag_a) !== 1'b1 && per < 70000);
	endtask : measure

	// Slow pin pulses so the two-flop synchroniser sees every edge
	task automatic pulse(input int k);
		repeat (k) begin
			@(posedge clk_in);
			ext_pin <= 1'b1;
			repeat (4) @(posedge clk_in);
			ext_pin <= 1'b0;
			repeat (4) @(posedge clk_in);
		end
		repeat (8) @(posedge clk_in);
	endtask : pulse

	initial begin
		#800000;
		mismatches++;
		final_report();
	end

	initial begin
		void'($urandom(59570));
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		for (i = 0; i < 8; i++) rd(i[2:0], 9'h000);
		wr(ADDR_COUNT_LOW, 8'hA5);
		wr(ADDR_COUNT_HIGH, 8'h5A);
		wr(3'h7, 8'hFF);
		rd(ADDR_COUNT_LOW, 9'h000);
		rd(ADDR_COUNT_HIGH, 9'h000);
		rd(3'h7, 9'h000);
		for (i = 1; i < 7; i++) begin
			if (i == 2 || i == 3) continue;
			v = 8'($urandom());
			wr(i[2:0], v);
			rd(i[2:0], {1'b0, v});
		end
		v = 8'($urandom()) & 8'hF0;
		wr(ADDR_CONTROL_ZERO, v);
		rd(ADDR_CONTROL_ZERO, {1'b0, v & CONTROL_ZERO_MASK});
		np = $urandom_range(3, 1);
		for (i = 0; i < 4; i++) begin
			setup({2'b00, i[1:0], 4'h0}, 16'h0020, 8'(np), CLK_SYS);
			measure(1'b1);
			check(per, 256 * np);
			check(other, 1);
			check(edges, (i == 3));
			check(active_out, 1'b1);
			if (i < 3) check(pin_out, (i == 2));
		end
		setup(8'hF0, 16'h0020, 8'(np), CLK_SYS);
		measure(1'b1);
		check(per, 256 * np);
		check(other, 1);
		check(active_out, 1'b0);
		setup(8'h31, 16'h0180, 8'h01, CLK_SYS);
		measure(1'b0);
		check(per, 384);
		check(other, 0);
		check(edges, 1);
		divs = '{4, 1, 16};
		for (i = 0; i < 3; i++) begin
			setup(8'h00, 16'h0020, 8'h01, i[2:0]);
			measure(1'b1);
			check(per, 256 * divs[i]);
		end
		pw_d[0] = 16'($urandom_range(511, 1));
		pw_c1 = '{8'hA9, 8'hA9, 8'hAD, 8'hA1, 8'h99, 8'h89};
		pw_d[1:5] = '{16'h0300, 16'd100, 16'd100, 16'd100, 16'd100};
		pw_h = '{int'(pw_d[0]), 512, 412, 412, 512, 0};
		for (i = 0; i < 6; i++) begin
			setup(pw_c1[i], pw_d[i], 8'h02, CLK_SYS);
			measure(1'b1);
			check(per, 512);
			check(high, pw_h[i]);
			// A compare value beyond the period is never reached
			check(other, (i != 1));
			check(active_out, 1'b1);
		end
		setup(8'hAB, 16'd600, 8'h01, CLK_SYS);
		measure(1'b0);
		check(per, 600);
		check(high, 256);
		check(other, 1);
		setup(8'h18, 16'h0005, 8'h00, CLK_PIN_RISE);
		repeat (4) @(negedge clk_in);
		check(pin_out, 1'b1);
		rd(ADDR_COUNT_LOW, 9'h000);
		rd(ADDR_COUNT_HIGH, 9'h000);
		pulse(3);
		rd(ADDR_COUNT_LOW, 9'h003);
		pulse(4);
		check(pin_out, 1'b0);
		wr(ADDR_CONTROL_ZERO, 8'hE8);
		pulse(4);
		rd(ADDR_COUNT_LOW, 9'h007);
		wr(ADDR_CONTROL_ZERO, 8'h68);
		pulse(3);
		rd(ADDR_COUNT_LOW, 9'h00A);
		wr(ADDR_CONTROL_ZERO, 8'h60);
		pulse(2);
		rd(ADDR_COUNT_LOW, 9'h00A);
		rd(ADDR_COUNT_LOW, 9'h100);
		repeat (2) @(negedge clk_in);
		check(last_rd, 8'h0A);
		wr(ADDR_CONTROL_ZERO, 8'h68);
		repeat (4) @(negedge clk_in);
		check(pin_out, 1'b1);
		rd(ADDR_COUNT_LOW, 9'h000);
		wr(ADDR_CONTROL_ZERO, 8'h70);
		wr(ADDR_CONTROL_ZERO, 8'h78);
		pulse(6);
		rd(ADDR_COUNT_LOW, 9'h006);
		repeat (4) @(posedge clk_in);
		final_report();
	end
endmodule : compact_timer_test
